// ### rtl/vfilt_pkg.sv
// Shared constants and types for the video enhancement filters
package vfilt_pkg;
    localparam int FIR_MAX = 15;
    localparam int FIR_CTR = 7;
    localparam int COEF_N = 24;
    localparam int COEF_SHIFT = 9;
    localparam int GAIN_SHIFT = 6;
    // Stage latencies in clock cycles
    localparam int L_MED = 2;
    localparam int L_FIR = 9;
    localparam int L_PEAK = 10;
    localparam int L_EDGE = 2;
    localparam int L_S2 = L_MED + L_FIR;
    localparam int L_ALL = L_S2 + L_FIR + L_PEAK + L_EDGE;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PEAK = 8'h04;
    localparam logic [7:0] ADDR_LTI = 8'h08;
    localparam logic [7:0] ADDR_CTI = 8'h0c;
    localparam logic [7:0] ADDR_NR = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_COEF = 8'h40;
    // Coefficient bank indices
    localparam int IDX_FLUMA = 0;
    localparam int IDX_FCHROMA = 8;
    localparam int IDX_MAINNR = 12;
    localparam int IDX_PEAK = 16;
    // Reset values
    localparam logic [10:0] COEF_UNITY = 11'h200;
    localparam logic [7:0] PEAK_GAIN_RST = 8'h40;
    localparam logic [9:0] PIX_MAX = 10'h3ff;

    typedef logic [10:0] coef_t;

    typedef struct packed {
        logic valid;
        logic hsync;
        logic vsync;
        logic [9:0] y;
        logic [9:0] cb;
        logic [9:0] cr;
    } pixel_t;

    typedef struct packed {
        logic peak_invert;
        logic peak_skip_sum;
        logic main_nr_mode;
        logic main_nr_enable;
        logic difference_select;
        logic front_chroma_fir_enable;
        logic front_luma_fir_enable;
        logic median_enable;
    } ctrl_t;
endpackage

// ### rtl/sym_fir.sv
// Symmetric FIR on a 15-sample line, fixed latency for any tap count
module sym_fir #(
    parameter int HALF = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Sample and coefficient bank, index 0 at centre
    input wire logic [9:0] din,
    input wire logic [HALF-1:0][10:0] coefs,
    // Result and the centre sample aligned to it
    output logic signed [15:0] fout,
    output logic [9:0] centre
);
    logic [9:0] line [vfilt_pkg::FIR_MAX];
    logic signed [26:0] prod [HALF];
    logic signed [26:0] acc;

    genvar k;
    generate
        for (k = 0; k < HALF; k++) begin : g_tap
            logic signed [11:0] pair;
            if (k == 0) begin : g_mid
                assign pair = $signed({2'b00, line[vfilt_pkg::FIR_CTR]});
            end else begin : g_side
                assign pair = $signed({2'b00, line[vfilt_pkg::FIR_CTR-k]})
                    + $signed({2'b00, line[vfilt_pkg::FIR_CTR+k]});
            end
            assign prod[k] = 27'(pair * $signed(coefs[k]));
        end
    endgenerate

    always_comb begin
        acc = '0;
        for (int i = 0; i < HALF; i++) begin
            acc = acc + prod[i];
        end
    end

    // Centre always sits at tap 7 so short filters keep the same delay
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < vfilt_pkg::FIR_MAX; i++) begin
                line[i] <= '0;
            end
            fout <= '0;
            centre <= '0;
        end else begin
            line[0] <= din;
            for (int i = 1; i < vfilt_pkg::FIR_MAX; i++) begin
                line[i] <= line[i-1];
            end
            fout <= 16'(acc >>> vfilt_pkg::COEF_SHIFT);
            centre <= line[vfilt_pkg::FIR_CTR];
        end
    end
endmodule

// ### rtl/core_gain.sv
// Coring, symmetric clipping and gain of a signed detail term
module core_gain (
    // Detail term in
    input wire logic signed [15:0] comp,
    // Shaping settings
    input wire logic [9:0] coring,
    input wire logic [9:0] limit,
    input wire logic [7:0] gain,
    // Shaped term out, gain 0x40 is unity
    output logic signed [15:0] term
);
    logic [15:0] mag;
    logic [15:0] cored;
    logic [15:0] clip;
    logic signed [24:0] prod;
    logic signed [24:0] scaled;

    assign mag = comp[15] ? 16'(-comp) : comp;
    // Small details below the coring level are treated as noise
    assign cored = (mag > {6'h00, coring}) ? mag - {6'h00, coring} : 16'h0000;
    assign clip = (cored > {6'h00, limit}) ? {6'h00, limit} : cored;
    assign prod = $signed({9'h000, clip}) * $signed({1'b0, gain});
    assign scaled = prod >>> vfilt_pkg::GAIN_SHIFT;
    assign term = comp[15] ? 16'(-scaled) : 16'(scaled);
endmodule

// ### rtl/video_enhance.sv
// Front noise, main noise, peaking and edge improvement pixel pipeline
// What this block does
// - Luma median of a 3-sample horizontal window per pixel.
// - Chroma skips the median, delayed only to stay aligned.
// - Median filters only when median_enable is set.
// - Front FIR: programmable 15-tap luma and 7-tap chroma filters.
// - Luma and chroma front FIRs have own enables; off passes unchanged.
// - Median input minus output is kept as median_difference.
// - Front FIR input minus output is kept as fir_difference.
// - difference_select picks which difference goes to noise reduction.
// - Main noise filter is a programmable 7-tap luma-only FIR.
// - main_nr_mode: fixed filters all pixels, surface only flat ones.
// - Peaking: 15-tap programmable filter, coring, limit, 256-level gain.
// - Eight symmetric peaking coefficients, signed 11 bits, 0x200 unity.
// - Peaking term cored, clipped, gained, then added to the input.
// - Peak gain resets to 0x40, which is unity gain.
// - Both bits set: peaking term is input minus low-pass output.
// - Luma edges: high-pass, core, unsigned gain, add to input.
// - Luma edge gain zero turns luma edge improvement off.
// - Cb and Cr get the same edge improvement with own settings.
//
// Local design decisions: the plain strobed port and the register addresses.
module video_enhance (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Pixel stream
    input wire vfilt_pkg::pixel_t in_pix,
    output vfilt_pkg::pixel_t out_pix,
    output logic signed [10:0] noise_difference,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    function automatic logic signed [17:0] ext(input logic [9:0] v);
        return $signed({8'h00, v});
    endfunction

    function automatic logic [9:0] sat10(input logic signed [17:0] v);
        if (v < 0) begin
            return 10'h000;
        end else if (v > ext(vfilt_pkg::PIX_MAX)) begin
            return vfilt_pkg::PIX_MAX;
        end
        return v[9:0];
    endfunction

    function automatic logic [9:0] med3(input logic [9:0] a,
                                        input logic [9:0] b,
                                        input logic [9:0] c);
        logic [9:0] lo;
        logic [9:0] hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        hi = (hi < c) ? hi : c;
        return (lo > hi) ? lo : hi;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // Registers
    vfilt_pkg::ctrl_t ctrl;
    logic [7:0] peak_gain;
    logic [9:0] peak_coring;
    logic [9:0] peak_sat;
    logic [7:0] edge_gain [3];
    logic [9:0] edge_cor [3];
    logic [9:0] nr_thresh;
    logic [vfilt_pkg::COEF_N-1:0][10:0] coef;
    logic signed [10:0] stat_md;
    logic signed [10:0] stat_fd;

    wire logic coef_hit = reg_addr >= vfilt_pkg::ADDR_COEF
        && reg_addr < 8'(vfilt_pkg::ADDR_COEF + 4 * vfilt_pkg::COEF_N)
        && reg_addr[1:0] == 2'h0;
    wire logic [5:0] coef_idx = reg_addr[7:2] - vfilt_pkg::ADDR_COEF[7:2];
    wire logic wr_ctrl = reg_wr && hit(reg_addr, vfilt_pkg::ADDR_CTRL);
    wire logic wr_peak = reg_wr && hit(reg_addr, vfilt_pkg::ADDR_PEAK);
    wire logic wr_lti = reg_wr && hit(reg_addr, vfilt_pkg::ADDR_LTI);
    wire logic wr_cti = reg_wr && hit(reg_addr, vfilt_pkg::ADDR_CTI);
    wire logic wr_nr = reg_wr && hit(reg_addr, vfilt_pkg::ADDR_NR);
    wire logic wr_coef = reg_wr && coef_hit;
    logic [31:0] rd_val;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl <= '0;
            peak_gain <= vfilt_pkg::PEAK_GAIN_RST;
            peak_coring <= '0;
            peak_sat <= vfilt_pkg::PIX_MAX;
            for (int i = 0; i < 3; i++) begin
                edge_gain[i] <= '0;
                edge_cor[i] <= '0;
            end
            nr_thresh <= '0;
            // Front and main NR centre taps at unity, peaking taps zero, so the filters start transparent
            for (int i = 0; i < vfilt_pkg::COEF_N; i++) begin
                coef[i] <= (i == vfilt_pkg::IDX_FLUMA
                    || i == vfilt_pkg::IDX_FCHROMA
                    || i == vfilt_pkg::IDX_MAINNR)
                    ? vfilt_pkg::COEF_UNITY : 11'h000;
            end
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata[7:0];
            end
            if (wr_peak) begin
                peak_gain <= reg_wdata[7:0];
                peak_coring <= reg_wdata[17:8];
                peak_sat <= reg_wdata[27:18];
            end
            if (wr_lti) begin
                edge_gain[0] <= reg_wdata[7:0];
                edge_cor[0] <= reg_wdata[17:8];
            end
            if (wr_cti) begin
                edge_gain[1] <= reg_wdata[7:0];
                edge_cor[1] <= {2'b00, reg_wdata[15:8]};
                edge_gain[2] <= reg_wdata[23:16];
                edge_cor[2] <= {2'b00, reg_wdata[31:24]};
            end
            if (wr_nr) begin
                nr_thresh <= reg_wdata[9:0];
            end
            if (wr_coef) begin
                coef[coef_idx[4:0]] <= reg_wdata[10:0];
            end
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (coef_hit) begin
            rd_val = {21'h000000, coef[coef_idx[4:0]]};
        end else begin
            case (reg_addr)
                vfilt_pkg::ADDR_CTRL: rd_val = {24'h000000, ctrl};
                vfilt_pkg::ADDR_PEAK: rd_val = {4'h0, peak_sat,
                    peak_coring, peak_gain};
                vfilt_pkg::ADDR_LTI: rd_val = {14'h0000, edge_cor[0],
                    edge_gain[0]};
                vfilt_pkg::ADDR_CTI: rd_val = {edge_cor[2][7:0],
                    edge_gain[2], edge_cor[1][7:0], edge_gain[1]};
                vfilt_pkg::ADDR_NR: rd_val = {22'h000000, nr_thresh};
                vfilt_pkg::ADDR_STAT: rd_val = {5'h00, stat_fd,
                    5'h00, stat_md};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
        end
    end

    // Sync delay, the reference every data path is matched to
    logic [2:0] sd [vfilt_pkg::L_ALL];
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < vfilt_pkg::L_ALL; i++) begin
                sd[i] <= '0;
            end
        end else begin
            sd[0] <= {in_pix.valid, in_pix.hsync, in_pix.vsync};
            for (int i = 1; i < vfilt_pkg::L_ALL; i++) begin
                sd[i] <= sd[i-1];
            end
        end
    end

    // Stage 1: luma median
    logic [9:0] w0;
    logic [9:0] w1;
    logic [9:0] s1_y;
    logic signed [10:0] s1_md;
    logic [19:0] c1 [vfilt_pkg::L_MED];
    wire logic [9:0] med_y = med3(in_pix.y, w0, w1);
    wire logic [9:0] next_s1_y = ctrl.median_enable ? med_y : w0;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            w0 <= '0;
            w1 <= '0;
            s1_y <= '0;
            s1_md <= '0;
            c1[0] <= '0;
            c1[1] <= '0;
        end else begin
            w0 <= in_pix.y;
            w1 <= w0;
            s1_y <= next_s1_y;
            s1_md <= 11'(ext(w0) - ext(next_s1_y));
            c1[0] <= {in_pix.cb, in_pix.cr};
            c1[1] <= c1[0];
        end
    end

    // Stage 2: front FIR on all three components
    logic signed [15:0] fy;
    logic signed [15:0] fcb;
    logic signed [15:0] fcr;
    logic [9:0] fy_c;
    logic [9:0] fcb_c;
    logic [9:0] fcr_c;

    sym_fir #(.HALF(8)) u_front_y (
        .core_clk(core_clk),
        .rstn(rstn),
        .din(s1_y),
        .coefs(coef[vfilt_pkg::IDX_FCHROMA-1:vfilt_pkg::IDX_FLUMA]),
        .fout(fy),
        .centre(fy_c)
    );
    sym_fir #(.HALF(4)) u_front_cb (
        .core_clk(core_clk),
        .rstn(rstn),
        .din(c1[1][19:10]),
        .coefs(coef[vfilt_pkg::IDX_MAINNR-1:vfilt_pkg::IDX_FCHROMA]),
        .fout(fcb),
        .centre(fcb_c)
    );
    sym_fir #(.HALF(4)) u_front_cr (
        .core_clk(core_clk),
        .rstn(rstn),
        .din(c1[1][9:0]),
        .coefs(coef[vfilt_pkg::IDX_MAINNR-1:vfilt_pkg::IDX_FCHROMA]),
        .fout(fcr),
        .centre(fcr_c)
    );

    wire logic y_on = ctrl.front_luma_fir_enable;
    wire logic c_on = ctrl.front_chroma_fir_enable;
    wire logic [9:0] s2_y = y_on ? sat10(18'(fy)) : fy_c;
    wire logic [9:0] s2_cb = c_on ? sat10(18'(fcb)) : fcb_c;
    wire logic [9:0] s2_cr = c_on ? sat10(18'(fcr)) : fcr_c;
    wire logic signed [10:0] fir_diff = 11'(ext(fy_c) - ext(s2_y));

    // Median difference waits out the FIR so both describe one pixel
    logic signed [10:0] md_d [vfilt_pkg::L_FIR];
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < vfilt_pkg::L_FIR; i++) begin
                md_d[i] <= '0;
            end
            noise_difference <= '0;
            stat_md <= '0;
            stat_fd <= '0;
        end else begin
            md_d[0] <= s1_md;
            for (int i = 1; i < vfilt_pkg::L_FIR; i++) begin
                md_d[i] <= md_d[i-1];
            end
            noise_difference <= ctrl.difference_select
                ? fir_diff : md_d[vfilt_pkg::L_FIR-1];
            if (sd[vfilt_pkg::L_S2-1][2]) begin
                stat_md <= md_d[vfilt_pkg::L_FIR-1];
                stat_fd <= fir_diff;
            end
        end
    end

    // Stage 3: main noise filter, luma only
    logic signed [15:0] fn;
    logic [9:0] fn_c;
    sym_fir #(.HALF(4)) u_main_nr (
        .core_clk(core_clk),
        .rstn(rstn),
        .din(s2_y),
        .coefs(coef[vfilt_pkg::IDX_PEAK-1:vfilt_pkg::IDX_MAINNR]),
        .fout(fn),
        .centre(fn_c)
    );
    wire logic signed [17:0] nr_dev = ext(fn_c) - 18'(fn);
    wire logic [17:0] nr_mag = nr_dev[17] ? 18'(-nr_dev) : nr_dev;
    // A pixel close to its smoothed value is taken as flat surface
    wire logic flat = nr_mag <= {8'h00, nr_thresh};
    wire logic nr_apply = ctrl.main_nr_enable
        && (!ctrl.main_nr_mode || flat);
    wire logic [9:0] s3_y = nr_apply ? sat10(18'(fn)) : fn_c;

    logic [19:0] c3 [vfilt_pkg::L_FIR];
    logic [19:0] c4 [vfilt_pkg::L_PEAK];
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < vfilt_pkg::L_FIR; i++) begin
                c3[i] <= '0;
            end
            for (int i = 0; i < vfilt_pkg::L_PEAK; i++) begin
                c4[i] <= '0;
            end
        end else begin
            c3[0] <= {s2_cb, s2_cr};
            for (int i = 1; i < vfilt_pkg::L_FIR; i++) begin
                c3[i] <= c3[i-1];
            end
            c4[0] <= c3[vfilt_pkg::L_FIR-1];
            for (int i = 1; i < vfilt_pkg::L_PEAK; i++) begin
                c4[i] <= c4[i-1];
            end
        end
    end

    // Stage 4: horizontal peaking
    logic signed [15:0] fp;
    logic [9:0] fp_c;
    logic signed [15:0] pk_term;
    logic [9:0] s4_y;
    sym_fir #(.HALF(8)) u_peak (
        .core_clk(core_clk),
        .rstn(rstn),
        .din(s3_y),
        .coefs(coef[vfilt_pkg::COEF_N-1:vfilt_pkg::IDX_PEAK]),
        .fout(fp),
        .centre(fp_c)
    );
    wire logic signed [15:0] pk_raw = ctrl.peak_invert ? 16'(-fp) : fp;
    wire logic signed [15:0] pk_comp = ctrl.peak_skip_sum
        ? 16'(ext(fp_c) + 18'(pk_raw)) : pk_raw;
    core_gain u_peak_gain (
        .comp(pk_comp),
        .coring(peak_coring),
        .limit(peak_sat),
        .gain(peak_gain),
        .term(pk_term)
    );
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s4_y <= '0;
        end else begin
            s4_y <= sat10(ext(fp_c) + 18'(pk_term));
        end
    end

    // Stage 5: edge improvement, luma then Cb and Cr
    logic [9:0] e_in [3];
    logic [9:0] e_out [3];
    assign e_in[0] = s4_y;
    assign e_in[1] = c4[vfilt_pkg::L_PEAK-1][19:10];
    assign e_in[2] = c4[vfilt_pkg::L_PEAK-1][9:0];

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_edge
            logic [9:0] e0;
            logic [9:0] e1;
            logic signed [15:0] hp;
            logic signed [15:0] term;
            assign hp = 16'((2 * ext(e0) - ext(e_in[ch]) - ext(e1)) >>> 1);
            core_gain u_edge (
                .comp(hp),
                .coring(edge_cor[ch]),
                .limit(vfilt_pkg::PIX_MAX),
                .gain(edge_gain[ch]),
                .term(term)
            );
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    e0 <= '0;
                    e1 <= '0;
                    e_out[ch] <= '0;
                end else begin
                    e0 <= e_in[ch];
                    e1 <= e0;
                    e_out[ch] <= (edge_gain[ch] == 8'h00) ? e0
                        : sat10(ext(e0) + 18'(term));
                end
            end
        end
    endgenerate

    assign out_pix.valid = sd[vfilt_pkg::L_ALL-1][2];
    assign out_pix.hsync = sd[vfilt_pkg::L_ALL-1][1];
    assign out_pix.vsync = sd[vfilt_pkg::L_ALL-1][0];
    assign out_pix.y = e_out[0];
    assign out_pix.cb = e_out[1];
    assign out_pix.cr = e_out[2];

    // Checks; window history kept apart from the datapath registers
    logic [9:0] y_p1;
    logic [9:0] y_p2;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            y_p1 <= '0;
            y_p2 <= '0;
        end else begin
            y_p1 <= in_pix.y;
            y_p2 <= y_p1;
        end
    end

    default clocking chk_clk @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    chk_sync_latency: assert property (
        $past(rstn, vfilt_pkg::L_ALL)
        |-> out_pix.valid == $past(in_pix.valid, vfilt_pkg::L_ALL))
        else $error("sync latency mismatch");
    chk_median_bound: assert property (
        $past(ctrl.median_enable)
        |-> s1_y >= ((y_p1 < y_p2) ? y_p1 : y_p2)
        && s1_y <= ((y_p1 < y_p2) ? y_p2 : y_p1))
        else $error("median outside window");
    chk_median_off: assert property (
        !$past(ctrl.median_enable) |-> s1_y == y_p2)
        else $error("median not bypassed");
    chk_median_diff: assert property (
        s1_md == 11'(ext(y_p2) - ext(s1_y)))
        else $error("median difference wrong");
    // Delay line holds reset zeros for two cycles after release
    chk_chroma_pass: assert property (
        $past(rstn, 2) |-> c1[1] == $past({in_pix.cb, in_pix.cr}, 2))
        else $error("chroma altered in median");
    chk_luma_fir_off: assert property (
        !y_on |-> s2_y == $past(s1_y, vfilt_pkg::L_FIR))
        else $error("luma fir not bypassed");
    chk_diff_select: assert property (
        ctrl.difference_select ##1 ctrl.difference_select
        |-> noise_difference == $past(fir_diff))
        else $error("difference select wrong");
    chk_gain_reset: assert property (
        $rose(rstn) |-> peak_gain == 8'h40)
        else $error("peak gain reset wrong");
    chk_edge_off: assert property (
        edge_gain[0] == 8'h00 && $past(edge_gain[0] == 8'h00)
        |-> out_pix.y == $past(s4_y, vfilt_pkg::L_EDGE))
        else $error("luma edge not bypassed");

    cov_median_changed: cover property (@(posedge core_clk)
        ctrl.median_enable && s1_md != 11'h000);
    cov_surface_skip: cover property (@(posedge core_clk)
        ctrl.main_nr_enable && ctrl.main_nr_mode && !flat);
    cov_peak_active: cover property (@(posedge core_clk)
        out_pix.valid && pk_term != 16'h0000);
endmodule

// ### dv/pix_source.sv
// Upstream stage model: one 16-pixel line with a luma spike at pixel 8
module pix_source (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Line request and levels
    input wire logic start,
    input wire logic [9:0] base,
    input wire logic [9:0] spike,
    // Pixel stream
    output vfilt_pkg::pixel_t pix
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] idx;

    // Idle at 16 so blanking stays flat and filters see no edge
    always_ff @(posedge core_clk) begin
        if (!rstn) idx <= 5'h10;
        else if (start) idx <= 5'h00;
        else if (!idx[4]) idx <= idx + 5'h01;
    end

    always_comb begin
        pix.valid = !idx[4];
        pix.hsync = (idx == 5'h00);
        pix.vsync = 1'b0;
        pix.y = (idx == 5'h08) ? spike : base;
        pix.cb = 10'h100;
        pix.cr = 10'h300;
    end
endmodule

// ### dv/video_noise_and_sharpness_filters_bench.sv
// Self-checking bench for the video enhancement pixel pipeline
module video_noise_and_sharpness_filters_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk;
    logic rstn;
    logic start;
    logic [9:0] base;
    logic [9:0] spike;
    vfilt_pkg::pixel_t in_pix;
    vfilt_pkg::pixel_t out_pix;
    logic signed [10:0] noise_difference;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] rd;
    logic [9:0] oy [16];
    logic [9:0] ocb [16];
    logic [9:0] ocr [16];
    logic [3:0] ocnt;
    logic signed [10:0] nd;
    int num_errors;
    int n_checks;

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    pix_source pix_source_inst (.core_clk(core_clk), .rstn(rstn),
        .start(start), .base(base), .spike(spike), .pix(in_pix));
    video_enhance video_enhance_inst (.core_clk(core_clk), .rstn(rstn),
        .in_pix(in_pix), .out_pix(out_pix),
        .noise_difference(noise_difference), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    // Line capture; only a nonzero difference is kept
    always @(posedge core_clk) begin
        if (out_pix.valid === 1'b1) begin
            if (out_pix.hsync === 1'b1) ocnt = 4'h0;
            oy[ocnt] = out_pix.y;
            ocb[ocnt] = out_pix.cb;
            ocr[ocnt] = out_pix.cr;
            ocnt = ocnt + 4'h1;
        end
        if (noise_difference !== 11'h000) nd = noise_difference;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    // Whole line plus pipeline flush
    task automatic run_line(input logic [9:0] b, input logic [9:0] s);
        nd = 11'h000;
        @(posedge core_clk);
        start <= 1'b1;
        base <= b;
        spike <= s;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (56) @(posedge core_clk);
    endtask

    task automatic t_regs;
        reg_read(vfilt_pkg::ADDR_PEAK);
        check(rd, 32'h0ffc0040);
        reg_read(8'h30);
        check(rd, 32'h00000000);
        $display("test regs done");
    endtask

    task automatic t_pass;
        run_line(10'h1f4, 10'h320);
        check(oy[8], 10'h320);
        check(oy[7], 10'h1f4);
        $display("test pass done");
    endtask

    task automatic t_median;
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h01);
        run_line(10'h1f4, 10'h320);
        check(oy[8], 10'h1f4);
        check(ocb[8], 10'h100);
        check(ocr[8], 10'h300);
        check(nd, 32'h12c);
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h09);
        run_line(10'h1f4, 10'h320);
        check(nd, 32'h0);
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h00);
        $display("test median done");
    endtask

    task automatic t_lti;
        reg_write(vfilt_pkg::ADDR_LTI, 32'h40);
        run_line(10'h1f4, 10'h258);
        check(oy[8], 10'h2bc);
        check(oy[7], 10'h1c2);
        run_line(10'h1f4, 10'h3e8);
        check(oy[8], 10'h3ff);
        reg_write(vfilt_pkg::ADDR_LTI, 32'h3240);
        run_line(10'h1f4, 10'h258);
        check(oy[8], 10'h28a);
        reg_write(vfilt_pkg::ADDR_LTI, 32'h0);
        $display("test lti done");
    endtask

    // Half centre, quarter each side: 0x320 spike on 0x1f4 gives 0x28a
    task automatic t_fir;
        reg_write(8'h40, 32'h100);
        reg_write(8'h44, 32'h80);
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h0a);
        run_line(10'h1f4, 10'h320);
        check(oy[8], 10'h28a);
        check({21'h000000, nd}, 32'h7b5);
        reg_write(8'h40, 32'h200);
        reg_write(8'h44, 32'h0);
        reg_write(8'h70, 32'h100);
        reg_write(8'h74, 32'h80);
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h10);
        run_line(10'h1f4, 10'h320);
        check(oy[8], 10'h28a);
        check(oy[7], 10'h23f);
        reg_write(vfilt_pkg::ADDR_NR, 32'h64);
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h30);
        run_line(10'h1f4, 10'h320);
        check(oy[8], 10'h320);
        check(oy[7], 10'h23f);
        reg_write(8'h70, 32'h200);
        reg_write(8'h74, 32'h0);
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h00);
        $display("test fir done");
    endtask

    // Zero peaking taps: low-pass mode term equals the input itself
    task automatic t_peak;
        reg_write(vfilt_pkg::ADDR_CTRL, 32'hc0);
        run_line(10'h12c, 10'h190);
        check(oy[8], 10'h320);
        check(oy[7], 10'h258);
        reg_write(vfilt_pkg::ADDR_PEAK, 32'h0ffc0020);
        run_line(10'h12c, 10'h190);
        check(oy[7], 10'h1c2);
        reg_write(vfilt_pkg::ADDR_PEAK, 32'h03200040);
        run_line(10'h12c, 10'h190);
        check(oy[7], 10'h1f4);
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h40);
        run_line(10'h12c, 10'h190);
        check(oy[8], 10'h258);
        reg_write(vfilt_pkg::ADDR_CTRL, 32'h00);
        $display("test peak done");
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #2000000;
        num_errors++;
        finish_test;
    end

    initial begin
        rstn = 1'b0;
        start = 1'b0;
        base = 10'h000;
        spike = 10'h000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ocnt = 4'h0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        t_regs;
        t_pass;
        t_median;
        t_lti;
        t_fir;
        t_peak;
        finish_test;
    end
endmodule
